// >>> icache_map.vh
// Address map, field layout and timing constants for the direct-mapped instruction cache
`ifndef ICACHE_MAP_VH
`define ICACHE_MAP_VH
`define TAG_ARRAY_BASE 32'hFFFFF000
`define TAG_ARRAY_LAST 32'hFFFFF3FF
`define DATA_ARRAY_BASE 32'hFFFFF400
`define DATA_ARRAY_LAST 32'hFFFFF7FF
`define ENTRY_COUNT 256
`define INDEX_HI 9
`define INDEX_LO 2
`define TAG_HI 24
`define TAG_LO 10
`define TAG_WIDTH 15
`define VALID_BIT 0
`define TAG_FIELD_LO 10
`define EN_DRAM_BIT 4
`define CS_SPACE_HI 8'h00
`define DRAM_SPACE_HI 8'h01
`define IDLE_CYCLES 1
`define EXTEND_CYCLES 1
`endif

// >>> tag_store.v
// Tag and valid store: 256 entries, one write port, one registered read port
`timescale 1ns/1ns
module tag_store #(
   parameter DEPTH = 256,
   parameter AW = 8,
   parameter TW = 15
) (
   input wire clk, // System clock
   input wire we, // Write strobe
   input wire [AW-1:0] waddr, // Write index
   input wire [TW-1:0] wtag, // Tag to store
   input wire wvalid, // Valid bit to store
   input wire [AW-1:0] raddr, // Read index
   output reg [TW-1:0] rtag, // Tag read out
   output reg rvalid // Valid read out
);
   reg [TW:0] mem [0:DEPTH-1];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= {wtag, wvalid};
      end
      rtag <= mem[raddr][TW:1];
      rvalid <= mem[raddr][0];
   end
endmodule // tag_store

// >>> icache.v
// Direct-mapped instruction cache with memory-mapped tag and data arrays and fill control
`timescale 1ns/1ns
`include "icache_map.vh"
// Function
// (RULE1) Control space holds a tag/valid array and a 4-byte line data array.
// (RULE2) Tag/valid array sits at FFFFF000-FFFFF3FF, 32-bit wide.
// (RULE3) Line data array sits at FFFFF400-FFFFF7FF, 32-bit wide.
// (RULE4) With caching off, both arrays behave as plain RAM.
// (RULE5) Tag array read returns the indexed entry's tag and valid bit.
// (RULE6) Tag array write stores tag and valid bit into the indexed entry.
// (RULE7) Data array read returns the indexed entry's line word.
// (RULE8) Data array write replaces the indexed entry's line word.
// (RULE9) Software clears all 256 valid bits before enabling caching.
// (RULE10) While caching is on, array writes are ignored and reads undefined.
// (RULE11) Software disables caching before forced array access.
// (RULE12) An isolated miss inserts one idle cycle before the fill.
// (RULE13) Back-to-back misses insert no idle cycle after the first.
// (RULE14) Chip-select fills stretch chip-select by one cycle on the last bus cycle.
// (RULE15) DRAM fills stretch row strobe by one cycle before cycle end.
// (RULE16) In row-strobe-low mode the bus cycle after a fill waits one cycle; the code holds it only after DRAM fills.
// (RULE17) First hit after a miss is filled as a miss without idle cycle.
// (RULE18) 256 entries, 15-bit tag compare, direct-mapped placement.
// (RULE19) Only fetches and PC-relative reads to CS or DRAM space are cacheable.
// (RULE20) Bit 4 enables DRAM space, bits 3..0 enable chip-select spaces 3..0.
// (RULE21) Each fill replaces the indexed entry's tag, valid bit and line.
// (RULE22) Entry index is address bits 9 down to 2.
module icache #(
   parameter ENTRIES = `ENTRY_COUNT,
   parameter IDX_W = 8,
   parameter TAG_W = `TAG_WIDTH
) (
   input wire CLOCK, // System clock, 250 MHz
   input wire RSTN, // Synchronous reset, active low
   input wire [4:0] CACHE_ENABLES, // dram_space_cache_enable and chip_select_space_cache_enables
   input wire RAS_DOWN_MODE, // DRAM row strobe kept low between accesses
   input wire FETCH_REQ, // CPU read request
   input wire FETCH_CACHEABLE, // Request is an instruction or PC-relative fetch
   input wire [31:0] FETCH_ADDR, // Request address
   output wire FETCH_READY, // Request served this cycle
   output reg [31:0] FETCH_DATA, // Read data
   input wire ARR_WR, // Array write strobe (CPU, direct_memory_access_controller, data_transfer_controller)
   output reg FILL_REQ, // External fill access request
   output reg [31:0] FILL_ADDR, // External fill address
   output reg FILL_DRAM, // Fill targets DRAM space
   input wire FILL_LAST, // Final bus cycle of the fill in progress
   input wire FILL_DONE, // Fill data valid, ends the fill
   input wire [31:0] FILL_DATA, // Fill data from the bus controller
   output reg CS_EXTEND, // Hold chip-select one more cycle
   output reg RAS_EXTEND, // Hold row strobe one more cycle
   output reg NEXT_CYCLE_HOLD, // Delay next bus cycle by one
   input wire [31:0] WR_DATA // Array write data
);
   localparam S_LOOK = 3'h0;
   localparam S_IDLE = 3'h1;
   localparam S_FILL = 3'h2;
   localparam S_EXT = 3'h3;
   localparam S_DONE = 3'h4;

   reg [2:0] state_r, state_nxt;
   reg miss_run_r; // Previous lookup ended in a miss
   reg [31:0] data_mem [0:ENTRIES-1];
   reg [31:0] line_r;
   reg [31:0] req_addr_r;
   wire [TAG_W-1:0] stored_tag;
   wire stored_valid;

   function [IDX_W-1:0] index_of;
      input [31:0] a;
      index_of = a[`INDEX_HI:`INDEX_LO]; // [RULE22]
   endfunction

   function in_range;
      input [31:0] a;
      input [31:0] lo;
      input [31:0] hi;
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Space decode from the top address byte; lookup uses both decodes, fill start only the DRAM one
   function dram_space;
      input [31:0] a;
      dram_space = a[31:24] == `DRAM_SPACE_HI;
   endfunction

   function cs_space;
      input [31:0] a;
      cs_space = a[31:24] == `CS_SPACE_HI;
   endfunction

   wire any_en = |CACHE_ENABLES;
   wire tag_hit_sel = in_range(FETCH_ADDR, `TAG_ARRAY_BASE, `TAG_ARRAY_LAST); // [RULE2]
   wire data_sel = in_range(FETCH_ADDR, `DATA_ARRAY_BASE, `DATA_ARRAY_LAST); // [RULE3]
   wire is_cs = cs_space(FETCH_ADDR);
   wire is_dram = dram_space(FETCH_ADDR);
   wire space_en = is_dram ? CACHE_ENABLES[`EN_DRAM_BIT] : (is_cs && CACHE_ENABLES[FETCH_ADDR[23:22]]); // [RULE20]
   wire cacheable = FETCH_REQ && FETCH_CACHEABLE && (is_cs || is_dram) && space_en; // [RULE19]
   wire arr_access = FETCH_REQ && (tag_hit_sel || data_sel);
   wire arr_write_ok = ARR_WR && arr_access && !any_en; // [RULE10] [RULE4]
   // Fill data arrives in the stretch state, after the last bus cycle
   wire fill_write = state_r == S_EXT && FILL_DONE; // [RULE21]

   // Lookup port reads the fetch index; fills write the held request's entry
   tag_store #(.DEPTH(ENTRIES), .AW(IDX_W), .TW(TAG_W)) u_tags (
      .clk(CLOCK),
      .we(fill_write || (arr_write_ok && tag_hit_sel)), // [RULE6] [RULE21]
      .waddr(fill_write ? index_of(req_addr_r) : index_of(FETCH_ADDR)),
      .wtag(fill_write ? req_addr_r[`TAG_HI:`TAG_LO] : WR_DATA[`TAG_FIELD_LO+TAG_W-1:`TAG_FIELD_LO]),
      .wvalid(fill_write ? 1'b1 : WR_DATA[`VALID_BIT]),
      .raddr(index_of(FETCH_ADDR)),
      .rtag(stored_tag),
      .rvalid(stored_valid)
   );

   always @(posedge CLOCK) begin
      if (fill_write) begin
         data_mem[index_of(req_addr_r)] <= FILL_DATA; // [RULE21]
      end else if (arr_write_ok && data_sel) begin
         data_mem[index_of(FETCH_ADDR)] <= WR_DATA; // [RULE8]
      end
      line_r <= data_mem[index_of(FETCH_ADDR)]; // [RULE7] [RULE1]
   end

   // Lookup result is one cycle after the request, so the request must be held until ready
   reg look_ph_r;
   wire hit = stored_valid && stored_tag == req_addr_r[`TAG_HI:`TAG_LO]; // [RULE18]
   wire tag_word_sel = in_range(req_addr_r, `TAG_ARRAY_BASE, `TAG_ARRAY_LAST);
   wire arr_read_done = look_ph_r && (tag_word_sel ||
      in_range(req_addr_r, `DATA_ARRAY_BASE, `DATA_ARRAY_LAST));
   reg look_cache_r;
   assign FETCH_READY = (state_r == S_DONE) ||
      (state_r == S_LOOK && look_ph_r && (arr_read_done || (look_cache_r && hit && !miss_run_r)));

   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_LOOK: begin
            if (look_ph_r && look_cache_r && (!hit || miss_run_r)) begin
               state_nxt = miss_run_r ? S_FILL : S_IDLE; // [RULE12] [RULE13] [RULE17]
            end
         end
         S_IDLE: state_nxt = S_FILL;
         S_FILL: begin
            if (FILL_LAST) begin
               state_nxt = S_EXT; // [RULE14] [RULE15]
            end
         end
         S_EXT: begin
            if (FILL_DONE) begin
               state_nxt = S_DONE;
            end
         end
         S_DONE: state_nxt = S_LOOK;
         default: state_nxt = S_LOOK;
      endcase
   end

   always @(posedge CLOCK) begin
      if (!RSTN) begin
         state_r <= S_LOOK;
         miss_run_r <= 1'b0;
         look_ph_r <= 1'b0;
         look_cache_r <= 1'b0;
         req_addr_r <= 32'h00000000;
         FETCH_DATA <= 32'h00000000;
         FILL_REQ <= 1'b0;
         FILL_ADDR <= 32'h00000000;
         FILL_DRAM <= 1'b0;
         CS_EXTEND <= 1'b0;
         RAS_EXTEND <= 1'b0;
         NEXT_CYCLE_HOLD <= 1'b0;
      end else begin
         state_r <= state_nxt;
         NEXT_CYCLE_HOLD <= 1'b0;
         if (state_r == S_LOOK) begin
            look_ph_r <= FETCH_REQ && !FETCH_READY && !look_ph_r;
            if (!look_ph_r) begin
               req_addr_r <= FETCH_ADDR;
               look_cache_r <= cacheable;
            end
            if (look_ph_r && arr_read_done) begin
               // Undefined while caching is on; zero is returned
               FETCH_DATA <= any_en ? 32'h00000000 : (tag_word_sel ?
                  {7'h00, stored_tag, 9'h000, stored_valid} : line_r); // [RULE5] [RULE10]
            end
            if (look_ph_r && look_cache_r && hit && !miss_run_r) begin
               FETCH_DATA <= line_r;
            end
            // A refilled hit ends the run, so the hit after it is served from the array
            if (look_ph_r && look_cache_r) begin
               miss_run_r <= !hit; // [RULE13] [RULE17]
            end
            if (look_ph_r && !look_cache_r) begin
               miss_run_r <= 1'b0;
            end
            // Run misses skip the idle state and start the fill straight from lookup
            if (state_nxt == S_FILL) begin
               FILL_REQ <= 1'b1;
               FILL_ADDR <= req_addr_r;
               FILL_DRAM <= dram_space(req_addr_r);
            end
         end
         if (state_r == S_IDLE) begin
            FILL_REQ <= 1'b1;
            FILL_ADDR <= req_addr_r;
            FILL_DRAM <= dram_space(req_addr_r);
         end
         // The stretch stands from the last bus cycle until the data is taken
         if (state_r == S_FILL && FILL_LAST) begin
            CS_EXTEND <= !FILL_DRAM; // [RULE14]
            RAS_EXTEND <= FILL_DRAM; // [RULE15]
         end
         if (state_r == S_EXT && FILL_DONE) begin
            FILL_REQ <= 1'b0;
            CS_EXTEND <= 1'b0;
            RAS_EXTEND <= 1'b0;
            FETCH_DATA <= FILL_DATA;
            NEXT_CYCLE_HOLD <= FILL_DRAM && RAS_DOWN_MODE; // [RULE16]
         end
      end
   end
endmodule // icache

// >>> icache_props.sv
// Assertions on the cache fetch and fill handshakes
`timescale 1ns/1ns
module icache_props (
   input wire CLOCK, // Clock
   input wire RSTN, // Reset
   input wire RAS_DOWN_MODE, // Row mode
   input wire FETCH_REQ, // Request
   input wire FETCH_CACHEABLE, // Cacheable
   input wire [31:0] FETCH_ADDR, // Address
   input wire FETCH_READY, // Served
   input wire [31:0] FETCH_DATA, // Data
   input wire FILL_REQ, // Fill
   input wire [31:0] FILL_ADDR, // Fill address
   input wire FILL_DRAM, // DRAM fill
   input wire FILL_LAST, // Last beat
   input wire FILL_DONE, // Fill end
   input wire [31:0] FILL_DATA, // Fill data
   input wire CS_EXTEND, // CS stretch
   input wire RAS_EXTEND, // RAS stretch
   input wire NEXT_CYCLE_HOLD // Bus hold
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   sequence fill_end; FILL_REQ && FILL_DONE; endsequence
   sequence last_beat; FILL_REQ && FILL_LAST; endsequence
   req_drop_a: assert property (fill_end |=> !FILL_REQ) else $error("fill req stuck");
   ready_fill_a: assert property (fill_end |=> FETCH_READY && FETCH_DATA == $past(FILL_DATA))
      else $error("fill answer wrong");
   cs_stretch_a: assert property (last_beat ##0 !FILL_DRAM |=> CS_EXTEND && !RAS_EXTEND)
      else $error("cs stretch missing");
   ras_stretch_a: assert property (last_beat ##0 FILL_DRAM |=> RAS_EXTEND && !CS_EXTEND)
      else $error("ras stretch missing");
   bus_hold_a: assert property (fill_end ##0 FILL_DRAM && RAS_DOWN_MODE |=> NEXT_CYCLE_HOLD)
      else $error("bus hold missing");
   hold_only_a: assert property (NEXT_CYCLE_HOLD |-> $past(FILL_DONE) && $past(FILL_DRAM) && $past(RAS_DOWN_MODE))
      else $error("bus hold unexpected");
   ext_clear_a: assert property (fill_end |=> !CS_EXTEND && !RAS_EXTEND)
      else $error("stretch not released");
   fill_addr_a: assert property ($rose(FILL_REQ) |-> FETCH_REQ && FILL_ADDR[31:2] == FETCH_ADDR[31:2]
      && FILL_DRAM == (FETCH_ADDR[31:24] == 8'h01)) else $error("fill address wrong");
   uncached_a: assert property (FETCH_REQ && !FETCH_CACHEABLE && !FILL_REQ |=> !FILL_REQ)
      else $error("uncached fill");
   ready_pulse_a: assert property (FETCH_READY |=> !FETCH_READY) else $error("ready too long");
endmodule // icache_props
bind icache icache_props icache_props_i (.CLOCK, .RSTN, .RAS_DOWN_MODE, .FETCH_REQ, .FETCH_CACHEABLE,
   .FETCH_ADDR, .FETCH_READY, .FETCH_DATA, .FILL_REQ, .FILL_ADDR, .FILL_DRAM, .FILL_LAST, .FILL_DONE,
   .FILL_DATA, .CS_EXTEND, .RAS_EXTEND, .NEXT_CYCLE_HOLD);

// >>> fill_responder.sv
// Bus controller model answering cache fills after a set lag
`timescale 1ns/1ns
module fill_responder (
   input wire clk, // Clock
   input wire rstn, // Reset
   input wire req, // Fill request
   input wire [31:0] addr, // Fill address
   input wire [1:0] lag, // Wait cycles
   output reg last, // Final beat
   output reg done, // Data valid
   output reg [31:0] data // Fill data
);
   reg [2:0] cnt_r;
   always @(posedge clk) begin
      last <= 1'b0;
      done <= 1'b0;
      // Bus is not held: data toggles when not returned
      data <= ~data;
      if (!rstn) begin
         cnt_r <= 3'h0;
         data <= 32'h0;
      end else if (req && !done) begin
         cnt_r <= cnt_r + 3'h1;
         last <= (cnt_r == {1'b0, lag});
         // One cycle gap leaves room for the stretch
         if (cnt_r == {1'b0, lag} + 3'h1) begin
            done <= 1'b1;
            data <= addr ^ 32'h5A5A5A5A;
         end
      end else begin
         cnt_r <= 3'h0;
      end
   end
endmodule // fill_responder

// >>> icache_tb.sv
// Self-checking bench for the instruction cache
`timescale 1ns/1ns
module icache_tb;
   reg CLOCK = 1'b0;
   reg RSTN = 1'b0;
   reg [4:0] CACHE_ENABLES = 5'h00;
   reg RAS_DOWN_MODE = 1'b0, FETCH_REQ = 1'b0, FETCH_CACHEABLE = 1'b0, ARR_WR = 1'b0;
   reg [31:0] FETCH_ADDR = 32'h0, WR_DATA = 32'h0;
   reg [1:0] lag = 2'h0;
   wire FETCH_READY, FILL_REQ, FILL_DRAM, FILL_LAST, FILL_DONE, CS_EXTEND, RAS_EXTEND, NEXT_CYCLE_HOLD;
   wire [31:0] FETCH_DATA, FILL_ADDR, FILL_DATA;
   integer err_total = 0, num_checks = 0, fills = 0, base = 0;
   always #2 CLOCK = ~CLOCK;
   icache icache_i (.CLOCK, .RSTN, .CACHE_ENABLES, .RAS_DOWN_MODE, .FETCH_REQ, .FETCH_CACHEABLE, .FETCH_ADDR,
      .FETCH_READY, .FETCH_DATA, .ARR_WR, .FILL_REQ, .FILL_ADDR, .FILL_DRAM, .FILL_LAST, .FILL_DONE,
      .FILL_DATA, .CS_EXTEND, .RAS_EXTEND, .NEXT_CYCLE_HOLD, .WR_DATA);
   fill_responder fill_responder_i (.clk(CLOCK), .rstn(RSTN), .req(FILL_REQ), .addr(FILL_ADDR), .lag(lag),
      .last(FILL_LAST), .done(FILL_DONE), .data(FILL_DATA));
   always @(posedge CLOCK) if (FILL_REQ && FILL_DONE) fills <= fills + 1;
   task chk(input [31:0] s, input [31:0] e, input [8*12:1] nm);
      begin
         num_checks = num_checks + 1;
         if (s !== e) begin
            err_total = err_total + 1;
            $display("unexpected %0s exp %h seen %h", nm, e, s);
         end
      end
   endtask
   // Returns cycles until ready; data is taken the cycle after ready
   task acc(input [31:0] a, input w, input [31:0] wd, input c, output [31:0] rd, output integer n);
      begin
         FETCH_ADDR = a;
         ARR_WR = w;
         WR_DATA = wd;
         FETCH_CACHEABLE = c;
         FETCH_REQ = 1'b1;
         n = 0;
         @(posedge CLOCK) #1;
         while (FETCH_READY !== 1'b1 && n < 50) begin
            @(posedge CLOCK) #1;
            n = n + 1;
         end
         chk(n < 50, 1, "ready");
         @(posedge CLOCK) #1;
         FETCH_REQ = 1'b0;
         rd = FETCH_DATA;
         @(posedge CLOCK) #1;
      end
   endtask
   task t_ram;
      reg [31:0] d;
      integer n;
      begin
         acc(32'hFFFFF004, 1, 32'h01FFFC01, 0, d, n);
         acc(32'hFFFFF404, 1, 32'hDEADBEEF, 0, d, n);
         acc(32'hFFFFF408, 1, 32'h5555AAAA, 0, d, n);
         acc(32'hFFFFF004, 0, 0, 0, d, n);
         chk(d, 32'h01FFFC01, "tag ram");
         acc(32'hFFFFF404, 0, 0, 0, d, n);
         chk(d, 32'hDEADBEEF, "data ram");
      end
   endtask
   task t_init;
      reg [31:0] d;
      integer i, n;
      begin
         for (i = 0; i < 256; i = i + 1) acc(32'hFFFFF000 + i * 4, 1, 0, 0, d, n);
         acc(32'hFFFFF004, 0, 0, 0, d, n);
         chk(d, 32'h0, "cleared");
      end
   endtask
   task t_timing;
      reg [31:0] d;
      integer n1, n, f;
      begin
         CACHE_ENABLES = 5'h1F;
         f = fills;
         acc(32'h00000104, 0, 0, 1, d, n1);
         chk(d, 32'h00000104 ^ 32'h5A5A5A5A, "fill data");
         base = n1 - 1;
         acc(32'h00400108, 0, 0, 1, d, n);
         chk(n, base, "run miss");
         acc(32'h00400108, 0, 0, 1, d, n);
         chk(n, base, "hit refill");
         acc(32'h00400108, 0, 0, 1, d, n);
         chk(fills - f, 3, "true hit");
         chk(n, 0, "hit lag");
         chk(d, 32'h00400108 ^ 32'h5A5A5A5A, "hit data");
         acc(32'h00000504, 0, 0, 1, d, n);
         chk(n, n1, "lone miss");
         acc(32'h00000104, 0, 0, 1, d, n);
         chk(fills - f, 5, "evicted");
      end
   endtask
   task t_spaces;
      reg [31:0] a, d;
      integer i, n, f;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            CACHE_ENABLES = 5'h01 << i;
            RAS_DOWN_MODE = (i == 4);
            lag = i[1:0];
            a = (i == 4) ? 32'h01000200 : {8'h00, i[1:0], 22'h200};
            f = fills;
            acc(a, 0, 0, 1, d, n);
            chk(fills - f, 1, "space fill");
            chk(d, a ^ 32'h5A5A5A5A, "space data");
            if (i < 4) chk(n, base + i, "fill lag");
         end
         RAS_DOWN_MODE = 1'b0;
      end
   endtask
   task t_locked;
      reg [31:0] d;
      integer n;
      begin
         acc(32'hFFFFF404, 1, 32'h12345678, 0, d, n);
         acc(32'hFFFFF104, 1, 32'h01FFFC00, 0, d, n);
         acc(32'hFFFFF404, 0, 0, 0, d, n);
         chk(d, 32'h0, "locked read");
         CACHE_ENABLES = 5'h00;
         acc(32'hFFFFF404, 0, 0, 0, d, n);
         chk(d, 32'hDEADBEEF, "locked data");
         acc(32'hFFFFF104, 0, 0, 0, d, n);
         chk(d, 32'h00000001, "filled tag");
      end
   endtask
   task close_out;
      begin
         $display("checks %0d errors %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (2) @(posedge CLOCK);
      #1 RSTN = 1'b1;
      t_ram;
      t_init;
      t_timing;
      t_spaces;
      t_locked;
      close_out;
   end
   initial begin
      #100000;
      err_total = err_total + 1;
      close_out;
   end
endmodule // icache_tb
